/* File: atx_keypad_power_control.v */
// Function
// RULE1: Software must give the sense pin the pull-up with strong pull-down mode and clear its user flag.
// RULE2: Software must give the power-control pin the high-impedance input mode and clear its user flag.
// RULE3: Software must give the reset-control pin the high-impedance input mode and clear its user flag.
// RULE4: Pin modes reset to the role defaults and software can store them as the boot state.
// RULE5: Power-on, hard off, hard reset and blanking each have their own enable bit.
// RULE6: With sense low, confirm held 0.25 s pulses power control for the set width.
// RULE7: With sense high, cancel held 4 s drives power control at least the set width.
// RULE8: If cancel stays held after the minimum, power control is driven up to 5 s more.
// RULE9: With sense high, confirm held 4 s drives reset control for 1 s.
// RULE10: When the reset pulse ends the device restarts itself.
// RULE11: With blanking enabled the display is blanked while sense is low.
// RULE12: Control pins float while idle and drive only during a pulse at the invert-selected level.
// RULE13: Five general pins, each usable as input or output under software control.
// RULE14: Pin two defaults to power control, pin three to reset control, pin one to power sense.
// RULE15: Pin four doubles as the sensor bus line and only ever drives low against its pull-up.
// RULE16: Hold counters restart on release and each action fires once per continuous hold.
`timescale 1ns/1ps
`include "atx_ctrl_defines.vh"
module atx_keypad_power_control #(
   parameter MS_CYCLES = `CLK_HZ / 1000
) (
   // Clock and reset
   input  wire       mclk_in,
   input  wire       sys_rst_in,
   // Register port
   input  wire [7:0] addr_in,
   input  wire [31:0] wdata_in,
   input  wire       wr_in,
   input  wire       rd_in,
   output reg  [31:0] rdata_out,
   // Keys
   input  wire       key_confirm_in,
   input  wire       key_cancel_in,
   // General pins
   input  wire [4:0] gpio_in,
   output reg  [4:0] gpio_out,
   output reg  [4:0] gpio_oe_out,
   // Display and self restart
   output reg        display_blank_out,
   output reg        self_restart_out
);
   // ---------------------------------------------
   // Configuration state
   // ---------------------------------------------
   reg  [15:0] atx_cfg;
   reg  [2:0]  drive_mode [0:4];
   reg  [4:0]  user_flag;
   reg  [4:0]  user_out;
   reg  [2:0]  boot_mode  [0:4];
   reg  [4:0]  boot_flag;
   wire        sense;
   wire        tick;
   wire        fire_on;
   wire        fire_off;
   wire        fire_rst;
   wire        idle;
   wire [31:0] units_prod;
   reg  [3:0]  cfg_read;
   integer     i;
   integer     k;

   localparam ST_IDLE   = 2'd0;
   localparam ST_PWR    = 2'd1;
   localparam ST_EXTEND = 2'd2;
   localparam ST_RST    = 2'd3;

   reg [1:0]  state;
   reg [15:0] pulse_ms;
   reg [15:0] units_ms;
   reg        hard_off;
   // Delays the restart to the pin release
   reg        restart_due;

   assign sense = gpio_in[1]; // RULE14
   assign idle  = (state == ST_IDLE);

   // ---------------------------------------------
   // Millisecond tick and key hold timers
   // ---------------------------------------------
   ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .tick_out   (tick)
   );

   hold_timer #(.THRESH_MS(`PWR_ON_HOLD_MS)) u_hold_on (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .tick_in    (tick),
      .key_in     (key_confirm_in),
      .arm_in     (atx_cfg[`CFG_PWR_ON_EN] && !sense), // RULE6
      .fire_out   (fire_on)
   );

   hold_timer #(.THRESH_MS(`HARD_HOLD_MS)) u_hold_off (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .tick_in    (tick),
      .key_in     (key_cancel_in),
      .arm_in     (atx_cfg[`CFG_HARD_OFF_EN] && sense), // RULE7
      .fire_out   (fire_off)
   );

   hold_timer #(.THRESH_MS(`HARD_HOLD_MS)) u_hold_rst (
      .mclk_in    (mclk_in),
      .sys_rst_in (sys_rst_in),
      .tick_in    (tick),
      .key_in     (key_confirm_in),
      .arm_in     (atx_cfg[`CFG_RESET_EN] && sense), // RULE9
      .fire_out   (fire_rst)
   );

   // ---------------------------------------------
   // Pulse width from 32 ms units
   // ---------------------------------------------
   assign units_prod = atx_cfg[`CFG_PULSE_MSB:`CFG_PULSE_LSB] * `UNIT_MS;

   always @* begin
      units_ms = units_prod[15:0];
   end

   // ---------------------------------------------
   // Register writes
   // ---------------------------------------------
   always @(posedge mclk_in) begin
      if (sys_rst_in) begin
         atx_cfg   <= {`PULSE_UNITS_RST, 8'h00};
         user_flag <= 5'h00;
         user_out  <= 5'h00;
         boot_flag <= 5'h00;
         for (i = 0; i < 5; i = i + 1) begin
            drive_mode[i] <= `DRIVE_HIZ_INPUT; // RULE4
            boot_mode[i]  <= `DRIVE_HIZ_INPUT;
         end
         drive_mode[1] <= `DRIVE_PULLUP_STRONG_DOWN; // RULE4
         boot_mode[1]  <= `DRIVE_PULLUP_STRONG_DOWN;
      end else if (self_restart_out) begin
         for (i = 0; i < 5; i = i + 1) begin
            drive_mode[i] <= boot_mode[i]; // RULE4
         end
         user_flag <= boot_flag;
      end else if (wr_in) begin
         if (addr_in == `REG_ATX_CFG) begin
            atx_cfg <= wdata_in[15:0]; // RULE5
         end else if (addr_in == `REG_GPIO_OUT) begin
            user_out <= wdata_in[4:0]; // RULE13
         end else if (addr_in == `REG_BOOT_CTRL && wdata_in[0]) begin
            for (i = 0; i < 5; i = i + 1) begin
               boot_mode[i] <= drive_mode[i]; // RULE4
            end
            boot_flag <= user_flag;
         end else begin
            for (i = 0; i < 5; i = i + 1) begin
               if (addr_in == `REG_GPIO_CFG0 + 4 * i) begin
                  drive_mode[i] <= wdata_in[2:0]; // RULE13
                  user_flag[i]  <= wdata_in[3];
               end
            end
         end
      end
   end

   // ---------------------------------------------
   // Pulse sequencer
   // ---------------------------------------------
   always @(posedge mclk_in) begin
      if (sys_rst_in) begin
         state            <= ST_IDLE;
         pulse_ms         <= 16'h0000;
         hard_off         <= 1'b0;
         restart_due      <= 1'b0;
         self_restart_out <= 1'b0;
      end else begin
         // Restart lands on the edge that releases the reset pin
         self_restart_out <= restart_due; // RULE10
         restart_due      <= 1'b0;
         case (state)
            ST_IDLE: begin
               pulse_ms <= 16'h0000;
               if (fire_on) begin
                  state    <= ST_PWR; // RULE6
                  hard_off <= 1'b0;
               end else if (fire_off) begin
                  state    <= ST_PWR; // RULE7
                  hard_off <= 1'b1;
               end else if (fire_rst) begin
                  state <= ST_RST; // RULE9
               end
            end
            ST_PWR: begin
               if (tick) begin
                  if (pulse_ms + 16'h0001 >= units_ms) begin
                     pulse_ms <= 16'h0000;
                     if (hard_off && key_cancel_in)
                        state <= ST_EXTEND; // RULE8
                     else
                        state <= ST_IDLE;
                  end else begin
                     pulse_ms <= pulse_ms + 16'h0001;
                  end
               end
            end
            ST_EXTEND: begin
               if (!key_cancel_in) begin
                  state <= ST_IDLE; // RULE8
               end else if (tick) begin
                  if (pulse_ms == `EXTEND_MS - 1)
                     state <= ST_IDLE; // RULE8
                  else
                     pulse_ms <= pulse_ms + 16'h0001;
               end
            end
            ST_RST: begin
               if (tick) begin
                  if (pulse_ms == `RESET_PULSE_MS - 1) begin
                     state       <= ST_IDLE;
                     restart_due <= 1'b1; // RULE10
                  end else begin
                     pulse_ms <= pulse_ms + 16'h0001;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------
   // Pin drivers and display
   // ---------------------------------------------
   always @(posedge mclk_in) begin
      if (sys_rst_in) begin
         gpio_out          <= 5'h00;
         gpio_oe_out       <= 5'h00;
         display_blank_out <= 1'b0;
      end else begin
         for (i = 0; i < 5; i = i + 1) begin
            if (user_flag[i] && drive_mode[i] != `DRIVE_HIZ_INPUT) begin
               gpio_out[i]    <= user_out[i]; // RULE13
               gpio_oe_out[i] <= (drive_mode[i] == `DRIVE_STRONG_BOTH) || !user_out[i];
            end else begin
               gpio_out[i]    <= 1'b0;
               gpio_oe_out[i] <= 1'b0;
            end
         end
         // Open drain only, pull-up makes the high
         gpio_out[4]    <= 1'b0; // RULE15
         gpio_oe_out[4] <= user_flag[4] && !user_out[4];
         if (!user_flag[2]) begin
            gpio_out[2]    <= !atx_cfg[`CFG_INVERT]; // RULE12
            gpio_oe_out[2] <= (state == ST_PWR) || (state == ST_EXTEND);
         end
         if (!user_flag[3]) begin
            gpio_out[3]    <= !atx_cfg[`CFG_INVERT]; // RULE12
            gpio_oe_out[3] <= (state == ST_RST);
         end
         display_blank_out <= atx_cfg[`CFG_BLANK_EN] && !sense; // RULE11
      end
   end

   // ---------------------------------------------
   // Read port, data stands one cycle after the strobe
   // ---------------------------------------------
   always @* begin
      // Unmapped addresses read as zero
      cfg_read = 4'h0;
      for (k = 0; k < 5; k = k + 1) begin
         if (addr_in == `REG_GPIO_CFG0 + 4 * k) begin
            cfg_read = {user_flag[k], drive_mode[k]}; // RULE13
         end
      end
   end

   always @(posedge mclk_in) begin
      if (sys_rst_in) begin
         rdata_out <= 32'h00000000;
      end else if (!rd_in) begin
         rdata_out <= 32'h00000000;
      end else begin
         case (addr_in)
            `REG_ATX_CFG: begin
               rdata_out <= {16'h0000, atx_cfg}; // RULE5
            end
            `REG_ATX_STATUS: begin
               rdata_out <= {27'h0000000, !idle, state, sense, display_blank_out};
            end
            `REG_GPIO_OUT: begin
               rdata_out <= {27'h0000000, user_out};
            end
            `REG_GPIO_IN: begin
               rdata_out <= {27'h0000000, gpio_in};
            end
            default: begin
               rdata_out <= {28'h0000000, cfg_read};
            end
         endcase
      end
   end
endmodule // atx_keypad_power_control

/* File: atx_ctrl_defines.vh */
`ifndef ATX_CTRL_DEFINES_VH
`define ATX_CTRL_DEFINES_VH

// Register byte addresses (address = index * 4)
`define REG_ATX_CFG        8'h00
`define REG_ATX_STATUS     8'h04
`define REG_GPIO_CFG0      8'h08
`define REG_GPIO_OUT       8'h1C
`define REG_GPIO_IN        8'h20
`define REG_BOOT_CTRL      8'h24

// ATX config field positions
`define CFG_PWR_ON_EN      0
`define CFG_HARD_OFF_EN    1
`define CFG_RESET_EN       2
`define CFG_BLANK_EN       3
`define CFG_INVERT         4
`define CFG_PULSE_LSB      8
`define CFG_PULSE_MSB      15

// Pin drive modes
`define DRIVE_PULLUP_STRONG_DOWN 3'h3
`define DRIVE_HIZ_INPUT          3'h2
`define DRIVE_STRONG_BOTH        3'h1

// Reset values
`define ATX_CFG_RST        16'h0000
`define PULSE_UNITS_RST    8'h20

// Timing
`define CLK_HZ             125000000
`define UNIT_MS            32
`define PWR_ON_HOLD_MS     250
`define HARD_HOLD_MS       4000
`define EXTEND_MS          5000
`define RESET_PULSE_MS     1000

`endif

/* File: ms_tick.v */
`timescale 1ns/1ps
// ---------------------------------------------
// Millisecond enable divider
// ---------------------------------------------
module ms_tick #(
   parameter CYCLES = 125000
) (
   // Clock and reset
   input  wire mclk_in,
   input  wire sys_rst_in,
   // Tick
   output reg  tick_out
);
   reg [31:0] count;

   always @(posedge mclk_in) begin
      if (sys_rst_in) begin
         count    <= 32'h00000000;
         tick_out <= 1'b0;
      end else if (count == CYCLES - 1) begin
         count    <= 32'h00000000;
         tick_out <= 1'b1;
      end else begin
         count    <= count + 32'h00000001;
         tick_out <= 1'b0;
      end
   end
endmodule // ms_tick

/* File: hold_timer.v */
`timescale 1ns/1ps
// ---------------------------------------------
// Key hold timer, fires once per hold
// ---------------------------------------------
module hold_timer #(
   parameter THRESH_MS = 250
) (
   // Clock and reset
   input  wire mclk_in,
   input  wire sys_rst_in,
   // Inputs
   input  wire tick_in,
   input  wire key_in,
   input  wire arm_in,
   // Fire pulse
   output reg  fire_out
);
   reg [15:0] count;
   reg        done;

   always @(posedge mclk_in) begin
      if (sys_rst_in) begin
         count    <= 16'h0000;
         done     <= 1'b0;
         fire_out <= 1'b0;
      end else begin
         fire_out <= 1'b0;
         if (!key_in) begin
            count <= 16'h0000; // RULE16
            done  <= 1'b0;
         end else if (tick_in && !done) begin
            if (count == THRESH_MS - 1) begin
               done     <= 1'b1; // RULE16
               fire_out <= arm_in;
            end else begin
               count <= count + 16'h0001;
            end
         end
      end
   end
endmodule // hold_timer

/* File: mb_host_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// Motherboard switch inputs and power rail
// ---------------------------------------------
module mb_host_model (
   // Clock and reset
   input  wire       mclk_in,
   input  wire       sys_rst_in,
   // Device pins
   input  wire [4:0] gpio_out,
   input  wire [4:0] gpio_oe_out,
   input  wire       pin0_ext,
   output wire [4:0] gpio_in,
   output reg        host_on
);
   reg        oe2_q;
   // Undriven pins two to four float up to their pull-ups
   wire [4:0] lvl = (gpio_oe_out & gpio_out) | ~gpio_oe_out;
   assign gpio_in = {lvl[4:2], host_on, gpio_oe_out[0] ? gpio_out[0] : pin0_ext};
   // Power switch toggles the rail when released
   always @(posedge mclk_in) begin
      oe2_q <= sys_rst_in ? 1'b0 : gpio_oe_out[2];
      if (sys_rst_in)
         host_on <= 1'b0;
      else if (oe2_q && !gpio_oe_out[2])
         host_on <= !host_on;
   end
endmodule // mb_host_model

/* File: atx_ctrl_asserts.sv */
`timescale 1ns/1ps
module atx_ctrl_asserts #(
   parameter MS_CYCLES = 125000
) (
   input wire        mclk_in,
   input wire        sys_rst_in,
   input wire [7:0]  addr_in,
   input wire [31:0] wdata_in,
   input wire        wr_in,
   input wire        rd_in,
   input wire [31:0] rdata_out,
   input wire        key_confirm_in,
   input wire        key_cancel_in,
   input wire [4:0]  gpio_in,
   input wire [4:0]  gpio_out,
   input wire [4:0]  gpio_oe_out,
   input wire        display_blank_out,
   input wire        self_restart_out
);
   int unsigned conf_cnt;
   int unsigned canc_cnt;
   int unsigned rst_cnt;
   // ---------------------------------------------
   // Hold and pulse length counters
   // ---------------------------------------------
   always @(posedge mclk_in) begin
      conf_cnt <= (key_confirm_in && !sys_rst_in) ? conf_cnt + 1 : 0;
      canc_cnt <= (key_cancel_in && !sys_rst_in) ? canc_cnt + 1 : 0;
      rst_cnt  <= (gpio_oe_out[3] && !sys_rst_in) ? rst_cnt + 1 : 0;
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   a_rdata_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("read data not zero outside read slot");
   a_pwr_after_hold: assert property ($rose(gpio_oe_out[2]) |->
      conf_cnt >= 249 * MS_CYCLES || canc_cnt >= 3999 * MS_CYCLES)
      else $error("power pulse without full key hold");
   a_rst_after_hold: assert property ($rose(gpio_oe_out[3]) |-> conf_cnt >= 3999 * MS_CYCLES)
      else $error("reset pulse without full key hold");
   a_rst_pulse_width: assert property ($fell(gpio_oe_out[3]) |->
      rst_cnt >= 999 * MS_CYCLES && rst_cnt <= 1001 * MS_CYCLES)
      else $error("reset pulse width wrong");
   a_restart_follows: assert property ($fell(gpio_oe_out[3]) |-> ##[0:3] self_restart_out)
      else $error("no self restart after reset pulse");
   a_restart_single: assert property (self_restart_out |=> !self_restart_out)
      else $error("self restart longer than one cycle");
   a_blank_sense_high: assert property (gpio_in[1] [*4] |=> !display_blank_out)
      else $error("display blanked while host is on");
   a_pulse_level_hold: assert property (gpio_oe_out[2] && $past(gpio_oe_out[2]) |-> $stable(gpio_out[2]))
      else $error("power pin level changed in a pulse");
   a_bus_pin_low: assert property (gpio_oe_out[4] |-> !gpio_out[4])
      else $error("sensor bus pin driven high");
   c_pwr: cover property ($rose(gpio_oe_out[2]));
   c_rst: cover property ($rose(gpio_oe_out[3]));
   c_restart: cover property (self_restart_out);
   c_blank: cover property ($fell(display_blank_out));
endmodule // atx_ctrl_asserts

bind atx_keypad_power_control atx_ctrl_asserts #(.MS_CYCLES(MS_CYCLES)) atx_ctrl_asserts_inst (
   .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .key_confirm_in(key_confirm_in),
   .key_cancel_in(key_cancel_in), .gpio_in(gpio_in), .gpio_out(gpio_out),
   .gpio_oe_out(gpio_oe_out), .display_blank_out(display_blank_out),
   .self_restart_out(self_restart_out));

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   localparam int MS = 2;
   logic        mclk_in = 0;
   logic        sys_rst_in = 1;
   logic [7:0]  addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0;
   logic        wr_in = 0;
   logic        rd_in = 0;
   logic        key_confirm_in = 0;
   logic        key_cancel_in = 0;
   logic        pin0_ext = 0;
   wire  [31:0] rdata_out;
   wire  [4:0]  gpio_in;
   wire  [4:0]  gpio_out;
   wire  [4:0]  gpio_oe_out;
   wire         display_blank_out;
   wire         self_restart_out;
   wire         host_on;
   int          n_mismatch = 0;
   int          check_count = 0;
   int          n;
   always #4 mclk_in = ~mclk_in;
   atx_keypad_power_control #(.MS_CYCLES(MS)) atx_keypad_power_control_inst (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .key_confirm_in(key_confirm_in),
      .key_cancel_in(key_cancel_in), .gpio_in(gpio_in), .gpio_out(gpio_out),
      .gpio_oe_out(gpio_oe_out), .display_blank_out(display_blank_out),
      .self_restart_out(self_restart_out));
   mb_host_model mb_host_model_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .gpio_out(gpio_out), .gpio_oe_out(gpio_oe_out), .pin0_ext(pin0_ext),
      .gpio_in(gpio_in), .host_on(host_on));
   // ---------------------------------------------
   // Shared helpers
   // ---------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1;
      chk(rdata_out, e);
   endtask
   // Counts settled cycles until an enable reaches a level
   task automatic wait_oe(input int b, input logic lvl, input int lim);
      n = 0;
      while (gpio_oe_out[b] !== lvl && n < lim) begin
         @(posedge mclk_in);
         #1;
         n++;
      end
   endtask
   task automatic rng(input int lo, input int hi);
      chk(n >= lo && n <= hi, 1'b1);
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_regs;
      rd(8'h00, 32'h2000);
      for (int i = 0; i < 5; i++)
         rd(8'h08 + 8'(4 * i), (i == 1) ? 32'h3 : 32'h2);
      rd(8'h40, 32'h0);
      wr(8'h08, 32'h9);
      wr(8'h1C, 32'h1);
      wr(8'h18, 32'h8);
      @(posedge mclk_in);
      #1;
      chk({gpio_oe_out[0], gpio_out[0]}, 2'b11);
      chk({gpio_oe_out[4], gpio_out[4]}, 2'b10);
      wr(8'h08, 32'h2);
      wr(8'h1C, 32'h10);
      pin0_ext <= 1'b1;
      repeat (4) @(posedge mclk_in);
      rd(8'h20, 32'h1D);
      $display("t_regs done");
   endtask
   task automatic t_power_on;
      wr(8'h00, 32'h0109);
      repeat (4) @(posedge mclk_in);
      chk(display_blank_out, 1'b1);
      key_confirm_in <= 1'b1;
      repeat (400) @(posedge mclk_in);
      key_confirm_in <= 1'b0;
      repeat (4) @(posedge mclk_in);
      chk(gpio_oe_out[2], 1'b0);
      key_confirm_in <= 1'b1;
      wait_oe(2, 1'b1, 600);
      rng(495, 506);
      chk(gpio_out[2], 1'b1);
      wait_oe(2, 1'b0, 200);
      rng(62, 67);
      @(posedge mclk_in);
      key_confirm_in <= 1'b0;
      repeat (8) @(posedge mclk_in);
      chk(display_blank_out, 1'b0);
      $display("t_power_on done");
   endtask
   task automatic t_off_disabled;
      @(posedge mclk_in);
      key_cancel_in <= 1'b1;
      wait_oe(2, 1'b1, 8300);
      chk(n, 8300);
      @(posedge mclk_in);
      key_cancel_in <= 1'b0;
      $display("t_off_disabled done");
   endtask
   task automatic t_host_reset;
      wr(8'h00, 32'h0104);
      key_confirm_in <= 1'b1;
      wait_oe(3, 1'b1, 8100);
      rng(7995, 8006);
      chk(gpio_out[3], 1'b1);
      @(posedge mclk_in);
      key_confirm_in <= 1'b0;
      wait_oe(3, 1'b0, 2100);
      rng(1996, 2004);
      n = 0;
      while (self_restart_out !== 1'b1 && n < 4) begin
         @(posedge mclk_in);
         #1;
         n++;
      end
      chk(self_restart_out, 1'b1);
      $display("t_host_reset done");
   endtask
   task automatic t_hard_off;
      repeat (4) @(posedge mclk_in);
      wr(8'h00, 32'h0112);
      key_cancel_in <= 1'b1;
      wait_oe(2, 1'b1, 8100);
      rng(7995, 8006);
      chk(gpio_out[2], 1'b0);
      repeat (300) @(posedge mclk_in);
      #1;
      chk(gpio_oe_out[2], 1'b1);
      rd(8'h04, 32'h1A);
      @(posedge mclk_in);
      key_cancel_in <= 1'b0;
      wait_oe(2, 1'b0, 10);
      rng(0, 9);
      $display("t_hard_off done");
   endtask
   task automatic test_done;
      $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      t_regs;
      t_power_on;
      t_off_disabled;
      t_host_reset;
      t_hard_off;
      test_done;
   end
   initial begin
      repeat (60000) @(posedge mclk_in);
      n_mismatch++;
      $display("Watchdog expired");
      test_done;
   end
endmodule // tb_top
